// File: uart_data_and_status_a.sv
// serial transceiver data port, status register a and frame engines behind apb
`timescale 1ns/10ps
`default_nettype none

// Function
// RL1: data writes fill tx buffer, reads return rx
// RL2: short characters: upper bits ignored, read zero
// RL3: tx write accepted only while buffer empty
// RL4: enabled transmitter loads idle shifter, shifts out
// RL5: two-entry rx fifo, each read pops one
// RL6: rx complete high exactly while fifo non-empty
// RL7: disabling receiver flushes the fifo
// RL8: tx complete set when frame done, buffer empty
// RL9: tx complete cleared by service or written one
// RL10: buffer empty flag shows tx buffer writable
// RL11: buffer empty flag set after reset
// RL12: framing error follows head character stop bit
// RL13: overrun when fifo full, shifter full, start
// RL14: parity error for head when checking enabled
// RL15: software writes zero to error flag bits
// RL16: double speed divides by eight in async
// RL17: software keeps double speed clear when synchronous
// RL18: filter drops frames without address marking
// RL19: divider value zero gives the fastest rate
// RL20: divider is twelve bits, high and low parts; here one 12-bit field in the ADDR_BAUD word
// RL21: ninth bit or stop bit marks address frame
// RL22: bit rate is clock over divisor times divider+1
module uart_data_and_status_a (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        txc_service,
	input  wire logic        rx_line,
	output logic             tx_line,
	output logic             tx_line_oe
);

	typedef struct packed {
		logic [11:0]       pre_cnt;
		logic              rx_en;
		logic              tx_en;
		logic [2:0]        size;
		logic [1:0]        pmode;
		logic              stop2;
		logic [1:0]        mode;
		logic              tx9;
		logic              dbl;
		logic              mpcm;
		logic [11:0]       baud;
		logic              hold_valid;
		logic [8:0]        hold_data;
		uart_pkg::tx_state_t tx_st;
		logic [3:0]        tx_os;
		logic [3:0]        tx_bit;
		logic [8:0]        tx_shift;
		logic              tx_par;
		logic              tx_out;
		logic              txc;
		logic [2:0]        rx_sync;
		logic              rx_level;
		uart_pkg::rx_state_t rx_st;
		logic [3:0]        rx_os;
		logic [3:0]        rx_bit;
		logic [8:0]        rx_shift;
		logic              rx_pe;
		logic              pend_valid;
		logic [10:0]       pend;
		logic [1:0][10:0]  fifo;
		logic              rd_ptr;
		logic              wr_ptr;
		logic [1:0]        count;
		logic              dor;
		logic [31:0]       rdata;
		logic              pop_ok;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	logic        setup;
	logic        access;
	logic        mapped;
	logic        os_tick;
	logic [3:0]  div_last;
	logic [3:0]  half_last;
	logic [3:0]  nbits;
	logic [8:0]  mask;
	logic [10:0] head;
	logic        frame_type;
	logic [8:0]  rx_data;

	assign setup      = psel & ~penable;
	assign access     = psel & penable;
	assign mapped     = (paddr == uart_pkg::ADDR_DATA) | (paddr == uart_pkg::ADDR_STATUS_A)
		| (paddr == uart_pkg::ADDR_CONTROL) | (paddr == uart_pkg::ADDR_BAUD);
	assign pready     = 1'b1;
	assign pslverr    = access & ~mapped;
	assign prdata     = st_ff.rdata;
	assign tx_line    = st_ff.tx_out;
	assign tx_line_oe = st_ff.tx_en | (st_ff.tx_st != uart_pkg::TX_IDLE) | st_ff.hold_valid;

	// ==========================================
	// baud timing
	assign os_tick   = (st_ff.pre_cnt == 12'h000);                                 // see RL19
	assign div_last  = (st_ff.dbl && st_ff.mode == uart_pkg::MODE_ASYNC)
		? uart_pkg::OS_DOUBLE : uart_pkg::OS_NORMAL;                                // see RL16
	assign half_last = {1'b0, div_last[3:1]};
	assign nbits     = uart_pkg::char_bits(st_ff.size);
	assign mask      = uart_pkg::char_mask(st_ff.size);
	assign head      = st_ff.fifo[st_ff.rd_ptr];
	assign rx_data   = st_ff.rx_shift & mask;                                      // see RL2
	assign frame_type = (st_ff.size == uart_pkg::SIZE_NINE) ? st_ff.rx_shift[8] : st_ff.rx_level;

	always_comb
	begin
		nxt_st = st_ff;

		// prescaler: (baud + 1) clocks per oversample tick
		if (os_tick)
			nxt_st.pre_cnt = st_ff.baud;                                            // see RL22
		else
			nxt_st.pre_cnt = st_ff.pre_cnt - 12'h001;

		// ==========================================
		// receive line synchroniser: a change counts once stages two and three agree
		nxt_st.rx_sync = {st_ff.rx_sync[1:0], rx_line};
		if (st_ff.rx_sync[1] == st_ff.rx_sync[2])
			nxt_st.rx_level = st_ff.rx_sync[2];

		// ==========================================
		// apb read snapshot at setup, so the pop matches what was returned
		if (setup && !pwrite)
		begin
			nxt_st.rdata  = 32'h0000_0000;
			nxt_st.pop_ok = 1'b0;
			case (paddr)
				uart_pkg::ADDR_DATA:
				begin
					nxt_st.rdata[7:0] = (st_ff.count != 2'h0) ? head[7:0] : 8'h00;    // see RL1
					nxt_st.pop_ok     = (st_ff.count != 2'h0);
				end
				uart_pkg::ADDR_STATUS_A:
				begin
					nxt_st.rdata[uart_pkg::SA_RXC]  = (st_ff.count != 2'h0);           // see RL6
					nxt_st.rdata[uart_pkg::SA_TXC]  = st_ff.txc;
					nxt_st.rdata[uart_pkg::SA_UDRE] = ~st_ff.hold_valid;              // see RL10
					nxt_st.rdata[uart_pkg::SA_FE]   = (st_ff.count != 2'h0) & head[uart_pkg::ENT_FE]; // see RL12
					nxt_st.rdata[uart_pkg::SA_DOR]  = st_ff.dor;
					nxt_st.rdata[uart_pkg::SA_UPE]  = (st_ff.count != 2'h0) & head[uart_pkg::ENT_PE]; // see RL14
					nxt_st.rdata[uart_pkg::SA_DBL]  = st_ff.dbl;
					nxt_st.rdata[uart_pkg::SA_MPCM] = st_ff.mpcm;
				end
				uart_pkg::ADDR_CONTROL:
				begin
					nxt_st.rdata[uart_pkg::CT_RX_EN]            = st_ff.rx_en;
					nxt_st.rdata[uart_pkg::CT_TX_EN]            = st_ff.tx_en;
					nxt_st.rdata[uart_pkg::CT_SIZE +: 3]        = st_ff.size;
					nxt_st.rdata[uart_pkg::CT_PMODE +: 2]       = st_ff.pmode;
					nxt_st.rdata[uart_pkg::CT_STOP2]            = st_ff.stop2;
					nxt_st.rdata[uart_pkg::CT_MODE +: 2]        = st_ff.mode;
					nxt_st.rdata[uart_pkg::CT_TX9]              = st_ff.tx9;
					nxt_st.rdata[uart_pkg::CT_RX9]              = (st_ff.count != 2'h0) & head[8];
				end
				uart_pkg::ADDR_BAUD:
					nxt_st.rdata[11:0] = st_ff.baud;                                   // see RL20
				default:
					nxt_st.rdata = 32'h0000_0000;
			endcase
		end

		// ==========================================
		// apb writes take effect at the access edge
		if (access && pwrite)
		begin
			case (paddr)
				uart_pkg::ADDR_DATA:
					if (!st_ff.hold_valid)                                            // see RL3
					begin
						nxt_st.hold_valid = 1'b1;
						nxt_st.hold_data  = {st_ff.tx9, pwdata[7:0]} & mask;             // see RL1
					end
				uart_pkg::ADDR_STATUS_A:
				begin
					// error flag positions are read-only; software writes zeros there
					nxt_st.dbl  = pwdata[uart_pkg::SA_DBL];                             // see RL15
					nxt_st.mpcm = pwdata[uart_pkg::SA_MPCM];
				end
				uart_pkg::ADDR_CONTROL:
				begin
					nxt_st.rx_en = pwdata[uart_pkg::CT_RX_EN];
					nxt_st.tx_en = pwdata[uart_pkg::CT_TX_EN];
					nxt_st.size  = pwdata[uart_pkg::CT_SIZE +: 3];
					nxt_st.pmode = pwdata[uart_pkg::CT_PMODE +: 2];
					nxt_st.stop2 = pwdata[uart_pkg::CT_STOP2];
					nxt_st.mode  = pwdata[uart_pkg::CT_MODE +: 2];
					nxt_st.tx9   = pwdata[uart_pkg::CT_TX9];
				end
				uart_pkg::ADDR_BAUD:
				begin
					// a new divider restarts the prescaler at once; frames in flight corrupt
					nxt_st.baud    = pwdata[11:0];                                      // see RL20
					nxt_st.pre_cnt = pwdata[11:0];
				end
				default:
					nxt_st.baud = st_ff.baud;
			endcase
		end

		// ==========================================
		// transmitter
		case (st_ff.tx_st)
			uart_pkg::TX_IDLE:
			begin
				nxt_st.tx_out = 1'b1;
				if (st_ff.hold_valid && st_ff.tx_en)                                  // see RL4
				begin
					nxt_st.tx_shift   = st_ff.hold_data;
					nxt_st.tx_par     = (^st_ff.hold_data) ^ st_ff.pmode[0];
					nxt_st.hold_valid = 1'b0;
					nxt_st.tx_st      = uart_pkg::TX_START;
					nxt_st.tx_os      = 4'h0;
					nxt_st.tx_out     = 1'b0;
				end
			end
			default:
				if (os_tick)
				begin
					nxt_st.tx_os = st_ff.tx_os + 4'h1;
					if (st_ff.tx_os == div_last)
					begin
						nxt_st.tx_os = 4'h0;
						case (st_ff.tx_st)
							uart_pkg::TX_START:
							begin
								nxt_st.tx_st  = uart_pkg::TX_DATA;
								nxt_st.tx_bit = 4'h0;
								nxt_st.tx_out = st_ff.tx_shift[0];
							end
							uart_pkg::TX_DATA:
								if (st_ff.tx_bit == nbits - 4'h1)
								begin
									nxt_st.tx_bit = 4'h0;
									nxt_st.tx_st  = st_ff.pmode[1] ? uart_pkg::TX_PAR : uart_pkg::TX_STOP;
									nxt_st.tx_out = st_ff.pmode[1] ? st_ff.tx_par : 1'b1;
								end
								else
								begin
									nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
									nxt_st.tx_out = st_ff.tx_shift[st_ff.tx_bit + 4'h1];
								end
							uart_pkg::TX_PAR:
							begin
								nxt_st.tx_st  = uart_pkg::TX_STOP;
								nxt_st.tx_bit = 4'h0;
								nxt_st.tx_out = 1'b1;
							end
							uart_pkg::TX_STOP:
								if (st_ff.stop2 && st_ff.tx_bit == 4'h0)
									nxt_st.tx_bit = 4'h1;
								else
								begin
									nxt_st.tx_st = uart_pkg::TX_IDLE;
									if (!nxt_st.hold_valid)
										nxt_st.txc = 1'b1;                                  // see RL8
								end
							default:
								nxt_st.tx_st = uart_pkg::TX_IDLE;
						endcase
					end
				end
		endcase

		// clear by service pulse or written one; a frame completing while the flag is clear wins
		if ((txc_service || (access && pwrite && paddr == uart_pkg::ADDR_STATUS_A
			&& pwdata[uart_pkg::SA_TXC])) && !(st_ff.txc == 1'b0 && nxt_st.txc))
			nxt_st.txc = 1'b0;                                                       // see RL9

		// ==========================================
		// receiver
		case (st_ff.rx_st)
			uart_pkg::RX_IDLE:
				if (st_ff.rx_en && !st_ff.rx_level)
				begin
					nxt_st.rx_st    = uart_pkg::RX_START;
					nxt_st.rx_os    = 4'h0;
					nxt_st.rx_shift = 9'h000;
					nxt_st.rx_pe    = 1'b0;
					if (st_ff.count == 2'h2 && st_ff.pend_valid)
						nxt_st.dor = 1'b1;                                                // see RL13
				end
			default:
				if (os_tick)
				begin
					nxt_st.rx_os = st_ff.rx_os + 4'h1;
					if (st_ff.rx_st == uart_pkg::RX_START && st_ff.rx_os == half_last)
					begin
						nxt_st.rx_os  = 4'h0;
						nxt_st.rx_bit = 4'h0;
						nxt_st.rx_st  = st_ff.rx_level ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
					end
					else if (st_ff.rx_st != uart_pkg::RX_START && st_ff.rx_os == div_last)
					begin
						nxt_st.rx_os = 4'h0;
						case (st_ff.rx_st)
							uart_pkg::RX_DATA:
							begin
								nxt_st.rx_shift[st_ff.rx_bit] = st_ff.rx_level;
								nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
								if (st_ff.rx_bit == nbits - 4'h1)
									nxt_st.rx_st = st_ff.pmode[1] ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
							end
							uart_pkg::RX_PAR:
							begin
								nxt_st.rx_pe = st_ff.rx_level != ((^rx_data) ^ st_ff.pmode[0]); // see RL14
								nxt_st.rx_st = uart_pkg::RX_STOP;
							end
							uart_pkg::RX_STOP:
							begin
								nxt_st.rx_st = uart_pkg::RX_IDLE;
								// frames with no address marking are dropped while filtering
								if (!(st_ff.mpcm && !frame_type) && !st_ff.pend_valid)       // see RL18 RL21
								begin
									nxt_st.pend_valid = 1'b1;
									nxt_st.pend = {~st_ff.rx_level, st_ff.rx_pe, rx_data};     // see RL12
								end
							end
							default:
								nxt_st.rx_st = uart_pkg::RX_IDLE;
						endcase
					end
				end
		endcase

		// ==========================================
		// receive fifo: the shift stage drains into it while there is room
		if (access && !pwrite && paddr == uart_pkg::ADDR_DATA && st_ff.pop_ok)
		begin
			nxt_st.rd_ptr = ~st_ff.rd_ptr;                                            // see RL5
			nxt_st.count  = nxt_st.count - 2'h1;
			// a start that flags overrun in this same cycle wins over the clear
			if (!(st_ff.rx_st == uart_pkg::RX_IDLE && st_ff.rx_en && !st_ff.rx_level
				&& st_ff.count == 2'h2 && st_ff.pend_valid))
				nxt_st.dor = 1'b0;                                                      // see RL13
		end
		if (st_ff.pend_valid && st_ff.count != 2'h2)
		begin
			nxt_st.fifo[st_ff.wr_ptr] = st_ff.pend;
			nxt_st.wr_ptr     = ~st_ff.wr_ptr;
			nxt_st.count      = nxt_st.count + 2'h1;
			nxt_st.pend_valid = 1'b0;
		end

		if (!st_ff.rx_en)
		begin
			nxt_st.count      = 2'h0;                                                 // see RL7
			nxt_st.rd_ptr     = 1'b0;
			nxt_st.wr_ptr     = 1'b0;
			nxt_st.pend_valid = 1'b0;
			nxt_st.dor        = 1'b0;
			nxt_st.rx_st      = uart_pkg::RX_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff            <= '0;
			st_ff.size       <= uart_pkg::SIZE_RESET;
			st_ff.baud       <= uart_pkg::BAUD_RESET;
			st_ff.hold_valid <= 1'b0;                                                 // see RL11
			st_ff.tx_out     <= 1'b1;
			st_ff.rx_sync    <= 3'h7;
			st_ff.rx_level   <= 1'b1;
			st_ff.tx_st      <= uart_pkg::TX_IDLE;
			st_ff.rx_st      <= uart_pkg::RX_IDLE;
		end
		else
			st_ff <= nxt_st;
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic data_wr;
	assign data_wr = access & pwrite & (paddr == uart_pkg::ADDR_DATA);

	a_full_write_drop: assert property (data_wr && st_ff.hold_valid && st_ff.tx_st != uart_pkg::TX_IDLE
		|=> st_ff.hold_valid && $stable(st_ff.hold_data)) else $error("write to full buffer landed"); // see RL3
	a_empty_write_take: assert property (data_wr && !st_ff.hold_valid
		|=> st_ff.hold_valid && st_ff.hold_data[7:0] == ($past(pwdata[7:0]) & mask[7:0]))
		else $error("write to empty buffer lost"); // see RL1
	a_rxc_read_back: assert property (setup && !pwrite && paddr == uart_pkg::ADDR_STATUS_A
		|=> prdata[uart_pkg::SA_RXC] == ($past(st_ff.count) != 2'h0)) else $error("rx complete wrong"); // see RL6
	a_rx_flush: assert property (!st_ff.rx_en |=> st_ff.count == 2'h0 && !st_ff.pend_valid)
		else $error("fifo not flushed"); // see RL7
	a_txc_on_done: assert property (st_ff.tx_st == uart_pkg::TX_STOP && nxt_st.tx_st == uart_pkg::TX_IDLE
		&& !nxt_st.hold_valid |=> st_ff.txc) else $error("tx complete missing"); // see RL8
	a_txc_service: assert property (txc_service && st_ff.tx_st == uart_pkg::TX_IDLE |=> !st_ff.txc)
		else $error("tx complete not cleared"); // see RL9
	a_tx_idle_high: assert property (st_ff.tx_st == uart_pkg::TX_IDLE |-> tx_line)
		else $error("idle line not high"); // see RL4
	a_start_bit_len: assert property (st_ff.tx_st == uart_pkg::TX_IDLE && nxt_st.tx_st == uart_pkg::TX_START
		&& st_ff.baud == 12'h000 && st_ff.dbl && st_ff.mode == uart_pkg::MODE_ASYNC
		|=> !tx_line [*8] ##1 st_ff.tx_st == uart_pkg::TX_DATA) else $error("start bit length"); // see RL16
	a_pop_one: assert property (access && !pwrite && paddr == uart_pkg::ADDR_DATA && st_ff.pop_ok
		&& st_ff.count == 2'h2 && st_ff.rx_en |=> st_ff.count == 2'h1) else $error("pop miscounted"); // see RL5

	c_tx_frame: cover property (st_ff.tx_st == uart_pkg::TX_STOP ##1 st_ff.tx_st == uart_pkg::TX_IDLE);
	c_rx_full: cover property (st_ff.count == 2'h2 && st_ff.pend_valid);
	c_overrun: cover property ($rose(st_ff.dor));
	c_pop: cover property (access && !pwrite && paddr == uart_pkg::ADDR_DATA && st_ff.pop_ok);

endmodule
`default_nettype wire

// File: uart_pkg.sv
// constants, types and helpers for the serial data port and status register a
`default_nettype none

package uart_pkg;

	// ==========================================
	// register map (byte addresses, one word each)
	localparam logic [11:0] ADDR_DATA      = 12'h000;
	localparam logic [11:0] ADDR_STATUS_A  = 12'h004;
	localparam logic [11:0] ADDR_CONTROL   = 12'h008;
	localparam logic [11:0] ADDR_BAUD      = 12'h00C;

	// ==========================================
	// serial_status_control_a fields
	localparam int SA_RXC  = 7;
	localparam int SA_TXC  = 6;
	localparam int SA_UDRE = 5;
	localparam int SA_FE   = 4;
	localparam int SA_DOR  = 3;
	localparam int SA_UPE  = 2;
	localparam int SA_DBL  = 1;
	localparam int SA_MPCM = 0;

	// ==========================================
	// control word fields
	localparam int CT_RX_EN  = 0;
	localparam int CT_TX_EN  = 1;
	localparam int CT_SIZE   = 2;
	localparam int CT_PMODE  = 5;
	localparam int CT_STOP2  = 7;
	localparam int CT_MODE   = 8;
	localparam int CT_TX9    = 10;
	localparam int CT_RX9    = 11;

	// ==========================================
	// receive entry layout: {fe, pe, data[8:0]}
	localparam int ENT_FE = 10;
	localparam int ENT_PE = 9;

	// ==========================================
	// reset values and timing
	localparam logic [11:0] BAUD_RESET   = 12'h000;
	localparam logic [2:0]  SIZE_RESET   = 3'h3;
	localparam logic [1:0]  MODE_ASYNC   = 2'h0;
	localparam logic [3:0]  OS_NORMAL    = 4'hF;
	localparam logic [3:0]  OS_DOUBLE    = 4'h7;
	localparam logic [2:0]  SIZE_NINE    = 3'h7;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;

	// data bits per character; reserved codes fall back to eight
	function automatic logic [3:0] char_bits(input logic [2:0] size);
		case (size)
			3'h0:    char_bits = 4'h5;
			3'h1:    char_bits = 4'h6;
			3'h2:    char_bits = 4'h7;
			3'h7:    char_bits = 4'h9;
			default: char_bits = 4'h8;
		endcase
	endfunction

	function automatic logic [8:0] char_mask(input logic [2:0] size);
		char_mask = 9'(({9'h000, 1'b1} << char_bits(size)) - 10'h001);
	endfunction

endpackage
`default_nettype wire

// File: remote_serial_model.sv
// behavioural far-end transceiver: sends frames into the block, collects frames it sends
`timescale 1ns/10ps
`default_nettype none

module remote_serial_model (
	input  wire logic        pclk,
	input  wire logic        line_in,
	output logic             line_out,
	input  wire logic [11:0] bit_clks,
	input  wire logic [3:0]  nbits
);
	// ==========================================
	// collected frames: {first stop bit, data}
	logic [9:0] got_q[$];

	// line rests at mark between frames, as a pulled-up idle line does
	initial line_out = 1'b1;

	task automatic put(input logic b);
		line_out <= b;
		repeat (bit_clks) @(posedge pclk);
	endtask

	// a zero stop or a wrong parity bit is only sent when the caller asks for it
	task automatic send(input logic [8:0] d, input int n, input logic pen, input logic pbit,
		input logic stp);
		int i;
		put(1'b0);
		for (i = 0; i < n; i++)
			put(d[i]);
		if (pen)
			put(pbit);
		put(stp);
		put(1'b1);
	endtask

	// ==========================================
	// receiver: samples mid-bit so register updates on the line never race the sample
	initial
	begin
		logic [8:0] v;
		int         i;
		forever
		begin
			@(negedge line_in);
			v = 9'h000;
			repeat (bit_clks / 2) @(posedge pclk);
			for (i = 0; i < nbits; i++)
			begin
				repeat (bit_clks) @(posedge pclk);
				v[i] = line_in;
			end
			repeat (bit_clks) @(posedge pclk);
			got_q.push_back({line_in, v});
		end
	end
endmodule

`default_nettype wire

// File: uart_data_and_status_a_tb.sv
// self-checking bench for the serial data port and status register a
`timescale 1ns/10ps
`default_nettype none

module uart_data_and_status_a_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        txc_service;
	logic        rx_line;
	logic        tx_line;
	logic        tx_line_oe;
	logic [11:0] bclk;
	logic [3:0]  nb;
	logic [31:0] q;
	logic        err;
	logic [7:0]  v[4];
	integer      seed;
	int          mismatches;
	int          total_checks;
	int          k;

	uart_data_and_status_a uart_data_and_status_a_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.txc_service(txc_service), .rx_line(rx_line), .tx_line(tx_line), .tx_line_oe(tx_line_oe)
	);

	remote_serial_model remote_serial_model_i (
		.pclk(pclk), .line_in(tx_line), .line_out(rx_line), .bit_clks(bclk), .nbits(nb)
	);

	initial
	begin
		pclk = 1'b0;
		forever
			#5 pclk = ~pclk;
	end

	// ==========================================
	// expectations
	function automatic logic [11:0] bit_time(input logic [11:0] b, input logic dbl);
		bit_time = (b + 12'h001) * (dbl ? 12'h008 : 12'h010);
	endfunction

	function automatic logic par_of(input logic [7:0] x);
		par_of = ^x;
	endfunction

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// ==========================================
	// apb master: holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dw);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dw;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			chk("pready", 32'h0000_0001, 32'h0000_0000);
			complete_run();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] dw);
		apb(1'b1, a, dw);
	endtask

	task automatic tx_chk(input logic [8:0] e);
		int n;
		n = 0;
		while (remote_serial_model_i.got_q.size() == 0 && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		if (remote_serial_model_i.got_q.size() == 0)
		begin
			chk("tx wait", 32'h0000_0001, 32'h0000_0000);
			complete_run();
		end
		chk("tx frame", {22'h00_0000, 1'b1, e}, {22'h00_0000, remote_serial_model_i.got_q.pop_front()});
	endtask

	// one byte each way at the current rate
	task automatic loop_byte(input logic [7:0] x);
		wr(uart_pkg::ADDR_DATA, {24'h00_0000, x});
		tx_chk({1'b0, x});
		remote_serial_model_i.send({1'b0, ~x}, 8, 1'b0, 1'b0, 1'b1);
		rd(uart_pkg::ADDR_DATA, {24'h00_0000, ~x}, "rx byte");
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		seed = 74;
		mismatches = 0;
		total_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		txc_service = 1'b0;
		bclk = bit_time(12'h000, 1'b0);
		nb = 4'h8;
		for (k = 0; k < 4; k++)
			v[k] = 8'($random(seed));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_0020, "status reset");
		rd(uart_pkg::ADDR_CONTROL, 32'h0000_000C, "control reset");
		rd(uart_pkg::ADDR_BAUD, 32'h0000_0000, "baud reset");
		rd(12'h010, 32'h0000_0000, "unmapped data");
		chk("unmapped err", 32'h0000_0001, {31'h0000_0000, err});
		chk("line enable off", 32'h0000_0000, {31'h0000_0000, tx_line_oe});
		wr(uart_pkg::ADDR_CONTROL, 32'h0000_000F);
		chk("line enable on", 32'h0000_0001, {31'h0000_0000, tx_line_oe});
		// back-to-back writes: the third finds the buffer full and is lost
		wr(uart_pkg::ADDR_DATA, {24'h00_0000, v[0]});
		wr(uart_pkg::ADDR_DATA, {24'h00_0000, v[1]});
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_0000, "status full");
		wr(uart_pkg::ADDR_DATA, {24'h00_0000, v[2]});
		tx_chk({1'b0, v[0]});
		tx_chk({1'b0, v[1]});
		repeat (400) @(posedge pclk);
		chk("tx count", 32'h0000_0000, remote_serial_model_i.got_q.size());
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_0060, "status done");
		wr(uart_pkg::ADDR_STATUS_A, 32'h0000_0040);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_0020, "txc w1c");
		wr(uart_pkg::ADDR_DATA, {24'h00_0000, v[3]});
		tx_chk({1'b0, v[3]});
		repeat (40) @(posedge pclk);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_0060, "txc set");
		txc_service <= 1'b1;
		@(posedge pclk);
		txc_service <= 1'b0;
		@(posedge pclk);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_0020, "txc service");
		// five-bit characters
		wr(uart_pkg::ADDR_CONTROL, 32'h0000_0003);
		nb = 4'h5;
		wr(uart_pkg::ADDR_DATA, 32'h0000_00FF);
		tx_chk(9'h01F);
		remote_serial_model_i.send(9'h0FF, 5, 1'b0, 1'b0, 1'b1);
		rd(uart_pkg::ADDR_DATA, 32'h0000_001F, "rx short");
		nb = 4'h8;
		wr(uart_pkg::ADDR_CONTROL, 32'h0000_000F);
		repeat (200) @(posedge pclk);
		wr(uart_pkg::ADDR_STATUS_A, 32'h0000_0040);
		// framing error follows the head character
		remote_serial_model_i.send({1'b0, v[0]}, 8, 1'b0, 1'b0, 1'b1);
		remote_serial_model_i.send({1'b0, v[1]}, 8, 1'b0, 1'b0, 1'b0);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_00A0, "fe head ok");
		rd(uart_pkg::ADDR_DATA, {24'h00_0000, v[0]}, "rx pop0");
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_00B0, "fe head bad");
		rd(uart_pkg::ADDR_DATA, {24'h00_0000, v[1]}, "rx pop1");
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_0020, "rx empty");
		// even parity wrong, then odd parity right
		wr(uart_pkg::ADDR_CONTROL, 32'h0000_004F);
		remote_serial_model_i.send({1'b0, v[2]}, 8, 1'b1, ~par_of(v[2]), 1'b1);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_00A4, "parity bad");
		rd(uart_pkg::ADDR_DATA, {24'h00_0000, v[2]}, "rx par");
		wr(uart_pkg::ADDR_CONTROL, 32'h0000_006F);
		remote_serial_model_i.send({1'b0, v[3]}, 8, 1'b1, ~par_of(v[3]), 1'b1);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_00A0, "parity ok");
		rd(uart_pkg::ADDR_DATA, {24'h00_0000, v[3]}, "rx par ok");
		wr(uart_pkg::ADDR_CONTROL, 32'h0000_000F);
		// four frames unread: fourth start finds fifo and shifter full
		for (k = 0; k < 4; k++)
			remote_serial_model_i.send({1'b0, v[k]}, 8, 1'b0, 1'b0, 1'b1);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_00A8, "overrun");
		for (k = 0; k < 3; k++)
			rd(uart_pkg::ADDR_DATA, {24'h00_0000, v[k]}, "rx after overrun");
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_0020, "overrun drained");
		// disabling the receiver flushes
		remote_serial_model_i.send({1'b0, v[0]}, 8, 1'b0, 1'b0, 1'b1);
		wr(uart_pkg::ADDR_CONTROL, 32'h0000_000E);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_0020, "rx flushed");
		wr(uart_pkg::ADDR_CONTROL, 32'h0000_000F);
		// address filter: a zero first stop marks a data frame
		wr(uart_pkg::ADDR_STATUS_A, 32'h0000_0001);
		remote_serial_model_i.send({1'b0, v[1]}, 8, 1'b0, 1'b0, 1'b0);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_0021, "filter drop");
		remote_serial_model_i.send({1'b0, v[2]}, 8, 1'b0, 1'b0, 1'b1);
		rd(uart_pkg::ADDR_STATUS_A, 32'h0000_00A1, "filter keep");
		rd(uart_pkg::ADDR_DATA, {24'h00_0000, v[2]}, "rx address");
		wr(uart_pkg::ADDR_STATUS_A, 32'h0000_0000);
		// nine-bit frames, two stops: the ninth bit marks address frames
		wr(uart_pkg::ADDR_CONTROL, 32'h0000_049F);
		nb = 4'h9;
		wr(uart_pkg::ADDR_DATA, {24'h00_0000, v[0]});
		tx_chk({1'b1, v[0]});
		wr(uart_pkg::ADDR_STATUS_A, 32'h0000_0001);
		remote_serial_model_i.send({1'b0, v[1]}, 9, 1'b0, 1'b0, 1'b1);
		remote_serial_model_i.send({1'b1, v[2]}, 9, 1'b0, 1'b0, 1'b1);
		rd(uart_pkg::ADDR_CONTROL, 32'h0000_0C9F, "rx ninth bit");
		rd(uart_pkg::ADDR_DATA, {24'h00_0000, v[2]}, "rx nine");
		wr(uart_pkg::ADDR_STATUS_A, 32'h0000_0040);
		wr(uart_pkg::ADDR_CONTROL, 32'h0000_000F);
		nb = 4'h8;
		// random bytes at normal, double speed and a slower divider
		for (k = 0; k < 3; k++)
			loop_byte(8'($random(seed)));
		wr(uart_pkg::ADDR_STATUS_A, 32'h0000_0002);
		bclk = bit_time(12'h000, 1'b1);
		loop_byte(8'($random(seed)));
		wr(uart_pkg::ADDR_STATUS_A, 32'h0000_0040);
		wr(uart_pkg::ADDR_BAUD, 32'h0000_0002);
		bclk = bit_time(12'h002, 1'b0);
		loop_byte(8'($random(seed)));
		rd(uart_pkg::ADDR_BAUD, 32'h0000_0002, "baud");
		complete_run();
	end
endmodule

`default_nettype wire
